//--- rtl/sbx_regs.vh
`ifndef SBX_REGS_VH
`define SBX_REGS_VH
// Operation select codes on i_op
`define SBX_OP_NONE 3'h0
`define SBX_OP_REG_SBC 3'h1
`define SBX_OP_IMM_SBC 3'h2
`define SBX_OP_PAGE_LOAD 3'h3
`define SBX_OP_HALT 3'h4
// Working register and flag reset values
`define SBX_RST_WORK 8'h00
`define SBX_RST_CARRY 1'h0
`define SBX_RST_ZERO 1'h0
`define SBX_RST_HALF 1'h0
`define SBX_RST_EXPIRY_N 1'h1
`define SBX_RST_HALT_N 1'h1
// Sizes
`define SBX_DATA_W 8
`define SBX_RADDR_W 6
`define SBX_SADDR_W 4
`define SBX_PAGE_DEPTH 16
// Cycles per instruction
`define SBX_EXEC_CYCLES 1
`endif

//--- rtl/sbx_page_mem.v
`timescale 1ns/1ps
`include "sbx_regs.vh"
// Special function page storage, registered read data
module sbx_page_mem #(
  parameter DW = 8,
  parameter AW = 4,
  parameter DEPTH = 16
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_we,
  input wire [AW-1:0] i_waddr,
  input wire [DW-1:0] i_wdata,
  input wire [AW-1:0] i_raddr,
  output reg [DW-1:0] o_rdata
);
  reg [DW-1:0] mem_reg [0:DEPTH-1];
  integer k;

  // Write port, reset to zero
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      for (k = 0; k < DEPTH; k = k + 1)
        mem_reg[k] <= {DW{1'b0}};
    end
    else if (i_we)
      mem_reg[i_waddr] <= i_wdata;
  end

  // Registered read
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_rdata <= {DW{1'b0}};
    else
      o_rdata <= mem_reg[i_raddr];
  end
endmodule // sbx_page_mem

//--- rtl/sbx_exec.v
`timescale 1ns/1ps
`include "sbx_regs.vh"
module sbx_exec #(
  parameter DW = `SBX_DATA_W,
  parameter RAW = `SBX_RADDR_W,
  parameter SAW = `SBX_SADDR_W
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_valid,
  input wire [2:0] i_op,
  input wire [RAW-1:0] i_raddr,
  input wire i_dest,
  input wire [DW-1:0] i_reg_data,
  input wire [DW-1:0] i_imm,
  input wire [SAW-1:0] i_page_raddr,
  input wire i_wake,
  output wire o_ready,
  output reg [DW-1:0] o_working_register,
  output reg o_carry_flag,
  output reg o_zero_flag,
  output reg o_half_carry_flag,
  output reg o_watchdog_expiry_flag_n,
  output reg o_halt_flag_n,
  output reg o_halted,
  output reg o_wdt_clear,
  output reg o_reg_we,
  output reg [RAW-1:0] o_reg_waddr,
  output reg [DW-1:0] o_reg_wdata,
  output wire [DW-1:0] o_page_rdata
);
  // One-hot run and halt states
  localparam [1:0] ST_RUN = 2'b01;
  localparam [1:0] ST_HALT = 2'b10;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [DW-1:0] operand;
  reg [DW:0] sum;
  reg [4:0] low_sum;
  reg page_we;
  wire take;
  // Decoded strobes of a taken instruction
  wire do_reg_sbc;
  wire do_imm_sbc;
  wire do_sbc;
  wire do_page;
  wire do_halt;
  wire to_reg;

  // Subtract with borrow: a + ~w + c, 9-bit result
  function [DW:0] sbc_sum;
    input [DW-1:0] a;
    input [DW-1:0] w;
    input c;
    begin
      sbc_sum = {1'b0, a} + {1'b0, ~w} + {{DW{1'b0}}, c};
    end
  endfunction

  // Opcode match for a taken instruction
  function op_hit;
    input taken;
    input [2:0] op;
    input [2:0] code;
    begin
      op_hit = taken && (op == code);
    end
  endfunction

  // Zero test of a result byte
  function is_zero;
    input [DW-1:0] v;
    begin
      is_zero = (v == {DW{1'b0}});
    end
  endfunction

  // Ready while running; taken on ready and valid
  assign o_ready = (state_reg == ST_RUN);
  assign take = i_valid && o_ready;

  // One strobe per instruction kind
  assign do_reg_sbc = op_hit(take, i_op, `SBX_OP_REG_SBC);
  assign do_imm_sbc = op_hit(take, i_op, `SBX_OP_IMM_SBC);
  assign do_sbc = do_reg_sbc || do_imm_sbc;
  assign do_page = op_hit(take, i_op, `SBX_OP_PAGE_LOAD);
  assign do_halt = op_hit(take, i_op, `SBX_OP_HALT);
  assign to_reg = do_reg_sbc && i_dest;

  // Operand select and arithmetic
  always @*
  begin
    operand = (i_op == `SBX_OP_IMM_SBC) ? i_imm : i_reg_data;
    sum = sbc_sum(operand, o_working_register, o_carry_flag);
    low_sum = {1'b0, operand[3:0]} + {1'b0, ~o_working_register[3:0]}
      + {4'h0, o_carry_flag};
    page_we = do_page;
  end

  // Halt state machine, left only by wake
  always @*
  begin
    case (state_reg)
      ST_RUN:
      begin
        state_next = do_halt ? ST_HALT : ST_RUN;
      end
      ST_HALT:
      begin
        state_next = i_wake ? ST_RUN : ST_HALT;
      end
      default:
      begin
        state_next = ST_RUN;
      end
    endcase
  end

  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      state_reg <= ST_RUN;
    else
      state_reg <= state_next;
  end

  // Working register: immediate form, or register form with d clear
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_working_register <= `SBX_RST_WORK;
    else if (do_sbc && !to_reg)
      o_working_register <= sum[DW-1:0];
  end

  // Status flags from either subtract form
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_carry_flag <= `SBX_RST_CARRY;
      o_zero_flag <= `SBX_RST_ZERO;
      o_half_carry_flag <= `SBX_RST_HALF;
    end
    else if (do_sbc)
    begin
      o_carry_flag <= sum[DW];
      o_zero_flag <= is_zero(sum[DW-1:0]);
      o_half_carry_flag <= low_sum[4];
    end
  end

  // Write back port toward register R
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_reg_we <= 1'b0;
      o_reg_waddr <= {RAW{1'b0}};
      o_reg_wdata <= {DW{1'b0}};
    end
    else
    begin
      o_reg_we <= to_reg;
      if (to_reg)
      begin
        o_reg_waddr <= i_raddr;
        o_reg_wdata <= sum[DW-1:0];
      end
    end
  end

  // Watchdog and prescaler clear, one cycle pulse
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_wdt_clear <= 1'b0;
    else
      o_wdt_clear <= do_halt;
  end

  // Halt status flags, held until reset
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_watchdog_expiry_flag_n <= `SBX_RST_EXPIRY_N;
      o_halt_flag_n <= `SBX_RST_HALT_N;
    end
    else if (do_halt)
    begin
      o_watchdog_expiry_flag_n <= 1'b1;
      o_halt_flag_n <= 1'b0;
    end
  end

  // Halted level follows the next state
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_halted <= 1'b0;
    else
      o_halted <= (state_next == ST_HALT);
  end

  // Special function page store
  sbx_page_mem #(
    .DW(DW),
    .AW(SAW),
    .DEPTH(`SBX_PAGE_DEPTH)
  ) u_page (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_we(page_we),
    .i_waddr(i_page_raddr),
    .i_wdata(o_working_register),
    .i_raddr(i_page_raddr),
    .o_rdata(o_page_rdata)
  );
endmodule // sbx_exec

//--- verification/sbx_rf.sv
`timescale 1ns/1ps
// Register file that feeds operand R and takes write back
module sbx_rf(
  input wire i_clk,
  input wire i_we,
  input wire [5:0] i_wa,
  input wire [7:0] i_wd,
  input wire [5:0] i_ra,
  output wire [7:0] o_rd
);
  reg [7:0] m [0:63];
  integer j;
  // Known start contents, no unknowns
  initial for (j=0;j<64;j=j+1) m[j]=j[7:0]^8'hA5;
  // Write back on request
  always @(posedge i_clk)
    if (i_we) m[i_wa]<=i_wd;
  assign o_rd=m[i_ra];
endmodule // sbx_rf

//--- verification/sbx_exec_assertions.sv
`timescale 1ns/1ps
module sbx_chk(
  input wire i_clk,
  input wire i_rst,
  input wire i_valid,
  input wire [2:0] i_op,
  input wire i_dest,
  input wire o_ready,
  input wire [7:0] o_working_register,
  input wire o_zero_flag,
  input wire o_watchdog_expiry_flag_n,
  input wire o_halt_flag_n,
  input wire o_wdt_clear,
  input wire o_reg_we
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Taken instruction decode
  wire g=i_valid&&o_ready;
  wire f=g&&i_op==3'h1;
  wire s=g&&i_op==3'h4;
  wire [7:0] w=o_working_register;
  property p_wb; f&&i_dest|=>o_reg_we; endproperty
  a_wb: assert property(p_wb) else $error("no write back");
  property p_nw; f&&!i_dest|=>!o_reg_we; endproperty
  a_nw: assert property(p_nw) else $error("stray write");
  property p_ks; f&&i_dest|=>$stable(w); endproperty
  a_ks: assert property(p_ks) else $error("w changed");
  property p_zf; g&&i_op==3'h2|=>o_zero_flag==(w==8'h00); endproperty
  a_zf: assert property(p_zf) else $error("zero flag");
  property p_pl; g&&i_op==3'h3|=>$stable(w); endproperty
  a_pl: assert property(p_pl) else $error("w changed");
  property p_wc; s|=>o_wdt_clear##1!o_wdt_clear; endproperty
  a_wc: assert property(p_wc) else $error("wdt clear");
  property p_fl; s|=>!o_halt_flag_n&&o_watchdog_expiry_flag_n; endproperty
  a_fl: assert property(p_fl) else $error("halt flags");
  property p_st; s|=>!o_ready; endproperty
  a_st: assert property(p_st) else $error("not stopped");
endmodule // sbx_chk
bind sbx_exec sbx_chk chk_u(.*);

//--- verification/sbx_exec_tb_top.sv
`timescale 1ns/1ps
module sbx_exec_tb_top;
  reg k=0,r=1,v=0,d=0,wk=0,p3=0;
  reg [2:0] op=0;
  reg [5:0] ra=0;
  reg [3:0] sa=0;
  reg [7:0] im=0,w0,pw;
  reg [2:0] f0=0,ro=0;
  reg [9:0] e;
  wire [7:0] rd,w,wd,pgd;
  wire [5:0] wa;
  wire ry,c,z,h,tn,pn,we,wc,ho;
  integer fail_count=0,samples_checked=0,n;
  // Free running clock
  always #4 k=~k;
  sbx_exec dut_u(.i_clk(k),.i_rst(r),.i_valid(v),.i_op(op),.i_raddr(ra),
    .i_dest(d),.i_reg_data(rd),.i_imm(im),.i_page_raddr(sa),.i_wake(wk),
    .o_ready(ry),.o_working_register(w),.o_carry_flag(c),.o_zero_flag(z),
    .o_half_carry_flag(h),.o_watchdog_expiry_flag_n(tn),.o_halt_flag_n(pn),
    .o_halted(ho),.o_wdt_clear(wc),.o_reg_we(we),.o_reg_waddr(wa),
    .o_reg_wdata(wd),.o_page_rdata(pgd));
  sbx_rf rf_u(.i_clk(k),.i_we(we),.i_wa(wa),.i_wd(wd),.i_ra(ra),.o_rd(rd));
  // Compare and count
  task chk(input [15:0] t,input [15:0] s,x);
    begin
      samples_checked=samples_checked+1;
      if (s!==x)
      begin
        fail_count=fail_count+1;
        $display("MISMATCH %s exp %h got %h",t,x,s);
      end
    end
  endtask
  // Subtract with borrow as half, carry, result
  function [9:0] sbc(input [7:0] a,b,input ci);
    reg [4:0] l;
    begin
      l={1'b0,a[3:0]}+{1'b0,~b[3:0]}+ci;
      sbc={l[4],{1'b0,a}+{1'b0,~b}+ci};
    end
  endfunction
  // Counts and verdict
  task summarize;
    begin
      $display("checks %0d errors %0d",samples_checked,fail_count);
      if (fail_count==0&&samples_checked>0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // One instruction, results checked one cycle later
  task run(input [2:0] o,input dd,input [7:0] i);
    begin
      op=o; d=dd; im=i; v=1; ra=$urandom;
      if (!p3) sa=$urandom;
      #1 e=sbc(o==1?rd:i,w,c);
      w0=w; f0={c,z,h};
      @(posedge k);
      #1;
      if (p3) chk("pg",pgd,pw);
      if (o==1||o==2)
      begin
        chk("wr",{we,o==1&&dd?wd:w},{o==1&&dd,e[7:0]});
        chk("fl",{c,z,h},{e[8],e[7:0]==8'h00,e[9]});
      end
      if (o==1&&dd) chk("wa",{w,2'h0,wa},{w0,2'h0,ra});
      if (o==3) chk("pl",{w,c,z,h,we},{w0,f0,1'b0});
      if (o==0||o>4) chk("no",{w,c,z,h,we,wc},{w0,f0,2'h0});
      if (o==4) chk("hl",{wc,tn,pn,ry,ho},5'h19);
      p3=o==3;
      pw=w0;
    end
  endtask
  // Reset, zero result corner, random mix, halt and wake
  initial
  begin
    n=$urandom(32'h6750);
    repeat(2) @(posedge k);
    #1 r=0;
    run(2,0,w+8'h01-c);
    for (n=0;n<80;n=n+1)
    begin
      ro=$urandom%8;
      if (ro==4) ro=3'h5;
      run(ro,$urandom,$urandom);
    end
    run(4,0,8'h00);
    op=2; w0=w; f0={c,z,h};
    @(posedge k);
    #1 chk("hd",{w,c,z,h,wc,ry,ho},{w0,f0,3'h1});
    v=0; wk=1;
    @(posedge k);
    #1 wk=0;
    chk("wk",{ry,wc,ho},3'h4);
    r=1;
    @(posedge k);
    #1 r=0;
    chk("rs",{w,c,z,h,tn,pn,ry,ho,wc},{8'h00,3'h0,5'h1C});
    summarize;
  end
  // Hang guard
  initial
  begin
    #9000;
    fail_count=fail_count+1;
    summarize;
  end
endmodule // sbx_exec_tb_top
